// File: common/ucs_pkg.sv
// shared constants of the collision / smart-card serial channel
// assumes a single mclk domain; register offsets are avalon byte addresses
package ucs_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_BAUD = 5'h04;
    localparam logic [4:0] ADDR_TXBUF = 5'h08;
    localparam logic [4:0] ADDR_RXBUF = 5'h0c;
    localparam logic [4:0] ADDR_STAT = 5'h10;

    // control register fields
    localparam int CTRL_W = 13;
    localparam int C_TX_ON = 0;
    localparam int C_RX_ON = 1;
    localparam int C_MODE_SC = 2;
    localparam int C_CLK_SRC = 3;
    localparam int C_PRE_LO = 4;
    localparam int C_TX_IRQ_SRC = 6;
    localparam int C_COLL_SAMPLE = 7;
    localparam int C_COLL_AUTOSTOP = 8;
    localparam int C_LAUNCH_SEL = 9;
    localparam int C_INVERSE = 10;
    localparam int C_ERR_SIG_EN = 11;
    localparam int C_STOP2 = 12;
    localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;

    // receive buffer flag positions
    localparam int RB_OVR = 12;
    localparam int RB_FRM = 13;
    localparam int RB_PAR = 14;
    localparam int RB_SUM = 15;

    // status register positions
    localparam int S_TXV = 0;
    localparam int S_TXE = 1;
    localparam int S_RXC = 2;
    localparam int S_TXIRQ = 3;
    localparam int S_RXIRQ = 4;
    localparam int S_COLL = 5;
    localparam int S_RXLVL = 6;
    localparam int S_TXERR = 7;

    // ----------------------------------------------------------------
    // bit timing: 16 ticks per bit, sample at the mid-bit edge
    // ----------------------------------------------------------------
    localparam logic [3:0] TICK_ZERO = 4'h0;
    localparam logic [3:0] SAMPLE_TICK = 4'h7;
    localparam logic [3:0] LAST_TICK = 4'hf;
    localparam logic [3:0] BIT_START = 4'h0;
    localparam logic [3:0] PAYLOAD_LAST = 4'h9;
    localparam logic [3:0] LAST_BIT1 = 4'ha;
    localparam logic [3:0] LAST_BIT2 = 4'hb;
    localparam logic [3:0] OVR_BIT1 = 4'h9;
    localparam logic [3:0] OVR_BIT2 = 4'ha;

    // prescaler terminal counts for divide by 1, 2, 8, 32
    localparam logic [4:0] PRE_TC_1 = 5'h00;
    localparam logic [4:0] PRE_TC_2 = 5'h01;
    localparam logic [4:0] PRE_TC_8 = 5'h07;
    localparam logic [4:0] PRE_TC_32 = 5'h1f;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_WAIT = 2'b01,
        TX_SHIFT = 2'b10
    } ucs_tx_t;

    typedef enum logic [0:0] {
        RX_IDLE = 1'b0,
        RX_RUN = 1'b1
    } ucs_rx_t;

endpackage : ucs_pkg

// File: common/ucs_if.sv
// bit-rate configuration and tick between the channel and its rate generator
// assumes both ends run on mclk
`timescale 1ns/1ps
`default_nettype none
interface ucs_if #(
    parameter int DIV_W = 8
) ();
    logic src_ext;
    logic [1:0] pre_sel;
    logic [DIV_W-1:0] divisor;
    logic ext_sync;
    logic tick;

    modport ctl (output src_ext, pre_sel, divisor, ext_sync, input tick);
    modport gen (input src_ext, pre_sel, divisor, ext_sync, output tick);
endinterface : ucs_if
`default_nettype wire

// File: logic/ucs_baud.sv
// oversampling tick generator: 16 ticks per bit
// assumes ext_sync is already synchronised to mclk
`timescale 1ns/1ps
`default_nettype none
module ucs_baud import ucs_pkg::*; #(
    parameter int DIV_W = 8 // divisor width
) (
    input wire logic mclk, // system clock
    input wire logic srst, // synchronous reset
    input wire logic ce, // clock enable
    ucs_if.gen bi // configuration in, tick out
);
    if (DIV_W < 1 || DIV_W > 16) begin : g_chk
        $error("ucs_baud: DIV_W must lie in 1..16");
    end

    logic [4:0] pre_q, pre_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic ext_prev_q, ext_prev_d;
    logic tick_q, tick_d;
    logic src_pulse;

    function automatic logic [4:0] pre_tc(input logic [1:0] sel);
        case (sel)
            2'h0: pre_tc = PRE_TC_1;
            2'h1: pre_tc = PRE_TC_2;
            2'h2: pre_tc = PRE_TC_8;
            default: pre_tc = PRE_TC_32;
        endcase
    endfunction : pre_tc

    // ----------------------------------------------------------------
    // source pulse, then divide by divisor plus one
    // ----------------------------------------------------------------
    always_comb begin
        ext_prev_d = bi.ext_sync;
        pre_d = (pre_q == pre_tc(bi.pre_sel)) ? 5'h00 : pre_q + 5'h01;
        src_pulse = bi.src_ext ? (bi.ext_sync & ~ext_prev_q)
                               : (pre_q == pre_tc(bi.pre_sel));
        div_d = div_q;
        tick_d = 1'b0;
        if (src_pulse) begin
            if (div_q >= bi.divisor) begin
                div_d = '0;
                tick_d = 1'b1;
            end else begin
                div_d = div_q + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pre_q <= 5'h00;
            div_q <= '0;
            ext_prev_q <= 1'b0;
            tick_q <= 1'b0;
        end else if (ce) begin
            pre_q <= pre_d;
            div_q <= div_d;
            ext_prev_q <= ext_prev_d;
            tick_q <= tick_d;
        end
    end

    assign bi.tick = tick_q;
endmodule : ucs_baud
`default_nettype wire

// File: logic/ucs_top.sv
// serial channel with bus-collision mode and smart-card mode
// assumes an avalon-mm master on mclk; rx and ext clock pins are async
`timescale 1ns/1ps
`default_nettype none
module ucs_top import ucs_pkg::*; #(
    parameter int DIV_W = 8 // baud divisor width
) (
    input wire logic mclk, // 40 MHz clock
    input wire logic srst, // synchronous reset, high
    input wire logic ce, // clock enable, freezes state
    input wire logic [4:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic rx_pin, // receive pin, async
    input wire logic ext_clock_pin, // external bit clock, async
    input wire logic oneshot_underflow, // collision one-shot underflow
    output logic tx_pin_o, // transmit pin level
    output logic tx_pin_oe_n, // transmit pin enable, low drives
    output logic tx_irq, // transmit request pending
    output logic rx_irq, // receive request pending
    output logic coll_irq // collision request pending
);
    if (DIV_W < 1 || DIV_W > 16) begin : g_chk
        $error("ucs_top: DIV_W must lie in 1..16");
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : merge

    // line order of a data byte; self-inverse, so serves both directions
    function automatic logic [7:0] fmt(input logic [7:0] d,
                                       input logic inv);
        for (int i = 0; i < 8; i++) fmt[i] = inv ? ~d[7-i] : d[i];
    endfunction : fmt

    // parity bit making the line even (direct) or odd (inverse)
    function automatic logic par(input logic [7:0] line_bits,
                                 input logic inv);
        par = inv ? ~(^line_bits) : (^line_bits);
    endfunction : par

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic rx_m_q, rx_s_q, rx_prev_q, ext_m_q, ext_s_q;
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [DIV_W-1:0] baud_q, baud_d;
    logic [8:0] txbuf_q, txbuf_d;
    logic txv_q, txv_d, txirq_q, txirq_d, rxirq_q, rxirq_d;
    logic coll_q, coll_d, txerr_q, txerr_d, ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d, wmerge;
    ucs_tx_t tx_st_q, tx_st_d;
    logic [3:0] tx_tick_q, tx_tick_d, tx_bit_q, tx_bit_d;
    logic [11:0] tx_sr_q, tx_sr_d, tx_frame;
    logic pin_q, pin_d, oen_q, oen_d;
    ucs_rx_t rx_st_q, rx_st_d;
    logic [3:0] rx_tick_q, rx_tick_d, rx_bit_q, rx_bit_d;
    logic [8:0] rx_sr_q, rx_sr_d, rxbuf_q, rxbuf_d;
    logic rxc_q, rxc_d, ovr_q, ovr_d, frm_q, frm_d, per_q, per_d;
    logic edrv_q, edrv_d, ovhit_q, ovhit_d, fmhit_q, fmhit_d;
    logic tick, coll_mode, inv, tx_on, rx_on, rx_rise, req, wr, rd;
    logic tx_load, tx_done, coll_hit, rx_evt, perr, ferr;
    logic [3:0] last_bit, ovr_bit;
    logic [8:0] payload;

    ucs_if #(.DIV_W(DIV_W)) bif ();

    assign coll_mode = ~ctrl_q[C_MODE_SC];
    assign inv = ctrl_q[C_INVERSE] & ~coll_mode;
    assign tx_on = ctrl_q[C_TX_ON];
    assign rx_on = ctrl_q[C_RX_ON];
    assign rx_rise = rx_s_q & ~rx_prev_q;
    assign last_bit = ctrl_q[C_STOP2] ? LAST_BIT2 : LAST_BIT1;
    assign ovr_bit = ctrl_q[C_STOP2] ? OVR_BIT2 : OVR_BIT1;
    assign bif.src_ext = ctrl_q[C_CLK_SRC];
    assign bif.pre_sel = ctrl_q[C_PRE_LO +: 2];
    assign bif.divisor = baud_q;
    assign bif.ext_sync = ext_s_q;
    assign tick = bif.tick;

    ucs_baud #(.DIV_W(DIV_W)) u_baud (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .bi(bif.gen)
    );

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            {rx_m_q, rx_s_q, rx_prev_q} <= 3'h7;
            {ext_m_q, ext_s_q} <= 2'h0;
        end else if (ce) begin
            rx_m_q <= rx_pin;
            rx_s_q <= rx_m_q;
            rx_prev_q <= rx_s_q;
            ext_m_q <= ext_clock_pin;
            ext_s_q <= ext_m_q;
        end
    end

    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    always_comb begin
        payload = coll_mode ? txbuf_q
                : {par(fmt(txbuf_q[7:0], inv), inv), fmt(txbuf_q[7:0], inv)};
        tx_frame = {2'h3, payload, 1'b0};
        tx_st_d = tx_st_q;
        tx_tick_d = tick ? tx_tick_q + 4'h1 : tx_tick_q;
        tx_bit_d = tx_bit_q;
        tx_sr_d = tx_sr_q;
        tx_load = 1'b0;
        tx_done = 1'b0;
        coll_hit = 1'b0;
        if (!tx_on) begin
            tx_st_d = TX_IDLE;
        end else begin
            case (tx_st_q)
                TX_IDLE: if (!txv_q) begin
                    tx_load = 1'b1;
                    tx_sr_d = tx_frame;
                    tx_tick_d = TICK_ZERO;
                    tx_bit_d = BIT_START;
                    tx_st_d = coll_mode ? TX_WAIT : TX_SHIFT;
                end
                TX_WAIT: if (ctrl_q[C_LAUNCH_SEL]) begin
                    if (rx_rise) begin
                        tx_st_d = TX_SHIFT;
                        tx_tick_d = TICK_ZERO;
                    end
                end else if (tick && tx_tick_q == LAST_TICK) begin
                    tx_st_d = TX_SHIFT;
                end
                TX_SHIFT: begin
                    // mismatch only counts while our frame is on the line
                    if (coll_mode && pin_q != rx_s_q &&
                        (ctrl_q[C_COLL_SAMPLE] ? oneshot_underflow
                        : (tick && tx_tick_q == SAMPLE_TICK))) begin
                        coll_hit = 1'b1;
                    end
                    if (tick && tx_tick_q == LAST_TICK) begin
                        tx_sr_d = {1'b1, tx_sr_q[11:1]};
                        tx_bit_d = tx_bit_q + 4'h1;
                        if (tx_bit_q == last_bit) begin
                            tx_st_d = TX_IDLE;
                            tx_done = 1'b1;
                        end
                    end
                end
                default: tx_st_d = TX_IDLE;
            endcase
        end
        // next error drive, so the pin moves on the edge the flag moves
        pin_d = ((tx_st_q == TX_SHIFT) ? tx_sr_q[0] : 1'b1) & ~edrv_d;
        oen_d = coll_mode ? pin_d : 1'b0;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_st_q <= TX_IDLE;
            tx_tick_q <= TICK_ZERO;
            tx_bit_q <= BIT_START;
            tx_sr_q <= 12'hfff;
            pin_q <= 1'b1;
            oen_q <= 1'b1;
        end else if (ce) begin
            tx_st_q <= tx_st_d;
            tx_tick_q <= tx_tick_d;
            tx_bit_q <= tx_bit_d;
            tx_sr_q <= tx_sr_d;
            pin_q <= pin_d;
            oen_q <= oen_d;
        end
    end

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    always_comb begin
        rx_st_d = rx_st_q;
        rx_tick_d = tick ? rx_tick_q + 4'h1 : rx_tick_q;
        rx_bit_d = rx_bit_q;
        rx_sr_d = rx_sr_q;
        rxbuf_d = rxbuf_q;
        {rxc_d, ovr_d, frm_d, per_d, edrv_d} =
            {rxc_q, ovr_q, frm_q, per_q, edrv_q};
        ovhit_d = ovhit_q;
        fmhit_d = fmhit_q;
        rx_evt = 1'b0;
        ferr = fmhit_q | ~rx_s_q;
        perr = ~coll_mode & (par(rx_sr_q[7:0], inv) != rx_sr_q[8]);
        // clears first so a same-cycle set wins
        if (rd && avs_address == ADDR_RXBUF) begin
            rxc_d = 1'b0;
            per_d = 1'b0;
            edrv_d = 1'b0;
        end
        if (!rx_on) begin
            rx_st_d = RX_IDLE;
            ovr_d = 1'b0;
            frm_d = 1'b0;
        end else begin
            case (rx_st_q)
                RX_IDLE: if (tick && !rx_s_q) begin
                    rx_st_d = RX_RUN;
                    rx_tick_d = TICK_ZERO;
                    rx_bit_d = BIT_START;
                    ovhit_d = 1'b0;
                    fmhit_d = 1'b0;
                end
                RX_RUN: if (tick && rx_tick_q == SAMPLE_TICK) begin
                    rx_bit_d = rx_bit_q + 4'h1;
                    if (rx_bit_q == BIT_START) begin
                        if (rx_s_q) begin
                            rx_st_d = RX_IDLE; // glitch, not a start bit
                        end
                    end else if (rx_bit_q <= PAYLOAD_LAST) begin
                        rx_sr_d = {rx_s_q, rx_sr_q[8:1]};
                    end else if (!rx_s_q) begin
                        fmhit_d = 1'b1;
                    end
                    if (rx_bit_q == ovr_bit && rxc_q) begin
                        ovr_d = 1'b1;
                        ovhit_d = 1'b1;
                    end
                    if (rx_bit_q == last_bit) begin
                        rx_st_d = RX_IDLE;
                        // an overrun frame is dropped without a request
                        if (!ovhit_q) begin
                            rxbuf_d = coll_mode ? rx_sr_q
                                    : {1'b0, fmt(rx_sr_q[7:0], inv)};
                            rxc_d = 1'b1;
                            rx_evt = 1'b1;
                            frm_d = frm_q | ferr;
                            per_d = per_q | perr;
                            edrv_d = edrv_d | (perr &
                                ctrl_q[C_ERR_SIG_EN]);
                        end
                    end
                end
                default: rx_st_d = RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_st_q <= RX_IDLE;
            rx_tick_q <= TICK_ZERO;
            rx_bit_q <= BIT_START;
            rx_sr_q <= 9'h000;
            rxbuf_q <= 9'h000;
            {rxc_q, ovr_q, frm_q, per_q, edrv_q} <= 5'h00;
            {ovhit_q, fmhit_q} <= 2'h0;
        end else if (ce) begin
            rx_st_q <= rx_st_d;
            rx_tick_q <= rx_tick_d;
            rx_bit_q <= rx_bit_d;
            rx_sr_q <= rx_sr_d;
            rxbuf_q <= rxbuf_d;
            {rxc_q, ovr_q, frm_q, per_q, edrv_q} <=
                {rxc_d, ovr_d, frm_d, per_d, edrv_d};
            {ovhit_q, fmhit_q} <= {ovhit_d, fmhit_d};
        end
    end

    // ----------------------------------------------------------------
    // register file and bus slave
    // ----------------------------------------------------------------
    // one wait state: read data is captured while waitrequest is high
    assign req = avs_read | avs_write;
    assign wr = avs_write & ack_q & ce;
    assign rd = avs_read & ack_q & ce;
    assign avs_waitrequest = req & ~(ack_q & ce);
    assign avs_readdata = rdata_q;

    always_comb begin
        ack_d = req & ~ack_q;
        rdata_d = rdata_q;
        if (req && !ack_q) begin
            case (avs_address)
                ADDR_CTRL: rdata_d = 32'(ctrl_q);
                ADDR_BAUD: rdata_d = 32'(baud_q);
                ADDR_RXBUF: begin
                    rdata_d = 32'(rxbuf_q);
                    rdata_d[RB_OVR] = ovr_q;
                    rdata_d[RB_FRM] = frm_q;
                    rdata_d[RB_PAR] = per_q;
                    rdata_d[RB_SUM] = ovr_q | frm_q | per_q;
                end
                ADDR_STAT: rdata_d = 32'({txerr_q, rx_s_q, coll_q,
                    rxirq_q, txirq_q, rxc_q, tx_st_q == TX_IDLE, txv_q});
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        ctrl_d = ctrl_q;
        baud_d = baud_q;
        txbuf_d = txbuf_q;
        txv_d = txv_q | tx_load;
        txirq_d = txirq_q;
        rxirq_d = rxirq_q;
        coll_d = coll_q;
        txerr_d = tx_done ? ~rx_s_q : txerr_q;
        wmerge = 32'h0000_0000;
        if (wr) begin
            case (avs_address)
                ADDR_CTRL: begin
                    wmerge = merge(32'(ctrl_q), avs_writedata, avs_byteenable);
                    ctrl_d = wmerge[CTRL_W-1:0];
                end
                ADDR_BAUD: begin
                    wmerge = merge(32'(baud_q), avs_writedata, avs_byteenable);
                    baud_d = wmerge[DIV_W-1:0];
                end
                ADDR_TXBUF: begin
                    wmerge = merge(32'(txbuf_q), avs_writedata,
                                   avs_byteenable);
                    txbuf_d = wmerge[8:0];
                    txv_d = 1'b0;
                end
                ADDR_STAT: begin
                    wmerge = avs_writedata & {32{avs_byteenable[0]}};
                    txirq_d = txirq_q & ~wmerge[S_TXIRQ];
                    rxirq_d = rxirq_q & ~wmerge[S_RXIRQ];
                    coll_d = coll_q & ~wmerge[S_COLL];
                end
                default: wmerge = 32'h0000_0000;
            endcase
        end
        if (coll_hit && ctrl_q[C_COLL_AUTOSTOP]) begin
            ctrl_d[C_TX_ON] = 1'b0;
        end
        txirq_d = txirq_d | (ctrl_q[C_TX_IRQ_SRC] ? tx_done : tx_load);
        rxirq_d = rxirq_d | rx_evt;
        coll_d = coll_d | coll_hit;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_q <= CTRL_RST;
            baud_q <= '0;
            txbuf_q <= 9'h000;
            txv_q <= 1'b1;
            {txirq_q, rxirq_q, coll_q, txerr_q, ack_q} <= 5'h00;
            rdata_q <= 32'h0000_0000;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            baud_q <= baud_d;
            txbuf_q <= txbuf_d;
            txv_q <= txv_d;
            {txirq_q, rxirq_q, coll_q, txerr_q, ack_q} <=
                {txirq_d, rxirq_d, coll_d, txerr_d, ack_d};
            rdata_q <= rdata_d;
        end
    end

    assign tx_pin_o = pin_q;
    assign tx_pin_oe_n = oen_q;
    assign tx_irq = txirq_q;
    assign rx_irq = rxirq_q;
    assign coll_irq = coll_q;
endmodule : ucs_top
`default_nettype wire

// File: bench/ucs_sva.sv
// port assertions for the serial channel
// assumes it is bound onto ucs_top, one mclk domain
`timescale 1ns/1ps
`default_nettype none
module ucs_sva (
    input wire logic mclk, // clock
    input wire logic srst, // reset
    input wire logic ce, // enable
    input wire logic avs_read, // read
    input wire logic avs_write, // write
    input wire logic avs_waitrequest, // stall
    input wire logic [31:0] avs_readdata, // data
    input wire logic tx_pin_o, // tx level
    input wire logic tx_pin_oe_n, // tx enable
    input wire logic tx_irq, // tx req
    input wire logic rx_irq, // rx req
    input wire logic coll_irq // coll req
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    logic req;
    logic clr;
    assign req = avs_read || avs_write;
    assign clr = avs_write && !avs_waitrequest;
    sequence stall_s;
        req && avs_waitrequest && ce;
    endsequence
    reset_out_a: assert property (disable iff (1'h0) srst && ce |=>
        tx_pin_o && tx_pin_oe_n && !tx_irq && !rx_irq && !coll_irq)
        else $error("outputs not at reset level");
    idle_ready_a: assert property (!req |-> !avs_waitrequest)
        else $error("stall without request");
    one_wait_a: assert property (stall_s |=> !avs_waitrequest || !ce)
        else $error("answer late");
    one_ack_a: assert property (req && !avs_waitrequest |=>
        avs_waitrequest || !req) else $error("answer twice");
    data_hold_a: assert property (!req |=> $stable(avs_readdata))
        else $error("read data moved");
    open_drain_a: assert property (tx_pin_oe_n |-> tx_pin_o)
        else $error("released pin not high");
    tx_sticky_a: assert property (tx_irq && !clr |=> tx_irq)
        else $error("tx request lost");
    rx_sticky_a: assert property (rx_irq && !clr |=> rx_irq)
        else $error("rx request lost");
    coll_sticky_a: assert property (coll_irq && !clr |=> coll_irq)
        else $error("collision request lost");
endmodule : ucs_sva
`default_nettype wire

// File: bench/ucs_card.sv
// far node on the shared data line: card or colliding bus node
// assumes a pull-up on the line; released device pin reads high
`timescale 1ns/1ps
`default_nettype none
module ucs_card #(
    parameter int BT = 32 // mclk cycles per bit
) (
    input wire logic mclk, // clock
    input wire logic tx_o, // device level
    input wire logic tx_oe_n, // device enable, low drives
    output logic line // wire seen by the device
);
    logic drv = 1'h1;
    assign line = drv & (tx_oe_n | tx_o);
    // start, nine line bits, one stop; parity already in b[8]
    task automatic send(input logic [8:0] b);
        for (int i = 0; i < 11; i++) begin
            drv <= (i == 0) ? 1'h0 : (i == 10) ? 1'h1 : b[i-1];
            repeat (BT) @(posedge mclk);
        end
    endtask : send
    task automatic hold(input logic v);
        drv <= v;
    endtask : hold
endmodule : ucs_card
`default_nettype wire

// File: bench/ucs_top_bench.sv
// self-checking bench of the serial channel
// assumes divisor 1 at divide-by-1, so one bit is 32 mclk cycles
`timescale 1ns/1ps
`default_nettype none
module ucs_top_bench import ucs_pkg::*;;
    localparam int BT = 32;
    logic mclk, srst = 1'h1, rd, wr, wt, txo, txoe, txi, rxi, coli, line;
    logic ce = 1'h1, osu = 1'h0;
    logic [4:0] adr;
    logic [31:0] wd, rdat;
    int errors = 0, tests_run = 0;
    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end
    ucs_top u_dut (.mclk(mclk), .srst(srst), .ce(ce), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wt),
        .rx_pin(line), .ext_clock_pin(1'h0), .oneshot_underflow(osu),
        .tx_pin_o(txo), .tx_pin_oe_n(txoe), .tx_irq(txi), .rx_irq(rxi),
        .coll_irq(coli));
    ucs_card #(.BT(BT)) u_card (.mclk(mclk), .tx_o(txo), .tx_oe_n(txoe),
        .line(line));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("ERROR %0t got %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        do @(posedge mclk); while (wt !== 1'h0);
        r = rdat;
        wr <= 1'h0;
        rd <= 1'h0;
    endtask : bus
    function automatic logic [8:0] fr(input logic [7:0] d, input logic inv);
        logic [8:0] b;
        for (int i = 0; i < 8; i++) b[i] = inv ? ~d[7-i] : d[i];
        b[8] = inv ? ~^b[7:0] : ^b[7:0];
        return b;
    endfunction : fr
    task automatic summarize;
        if (errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        logic [31:0] r;
        bus(1'h0, ADDR_CTRL, 32'h0, r);
        chk(r, 32'h0);
        bus(1'h0, ADDR_STAT, 32'h0, r);
        chk(r & 32'h1, 32'h1);
        bus(1'h0, 5'h14, 32'h0, r);
        chk(r, 32'h0);
        bus(1'h1, ADDR_BAUD, 32'h1, r);
        // frozen clock enable must stretch the answer
        ce <= 1'h0;
        fork
            bus(1'h0, ADDR_BAUD, 32'h0, r);
            begin
                repeat (4) @(posedge mclk);
                chk(wt, 1'h1);
                ce <= 1'h1;
            end
        join
        chk(r, 32'h1);
    endtask : t_regs
    task automatic t_tx(input logic inv, input logic [7:0] d);
        logic [31:0] r;
        logic [9:0] got;
        bus(1'h1, ADDR_CTRL, 32'h45 | (32'(inv) << C_INVERSE), r);
        repeat (2 * BT) @(posedge mclk);
        chk(txo, 1'h1);
        bus(1'h1, ADDR_TXBUF, {24'h0, d}, r);
        wait (txo === 1'h0);
        repeat (BT / 2) @(posedge mclk);
        for (int i = 0; i < 10; i++) begin
            repeat (BT) @(posedge mclk);
            got[i] = txo;
        end
        chk(got, {1'h1, fr(d, inv)});
        // card returns an error on the inverse frame only
        u_card.hold(!inv);
        repeat (BT) @(posedge mclk);
        chk(txi, 1'h1);
        u_card.hold(1'h1);
        bus(1'h0, ADDR_STAT, 32'h0, r);
        chk(r[S_TXERR], inv);
        bus(1'h1, ADDR_STAT, 32'h8, r);
        @(negedge mclk);
        chk(txi, 1'h0);
    endtask : t_tx
    task automatic t_rx(input logic bad, input logic [7:0] d);
        logic [31:0] r;
        bus(1'h1, ADDR_CTRL, 32'h806, r);
        u_card.send(fr(d, 1'h0) ^ {bad, 8'h0});
        chk(rxi, 1'h1);
        chk(txo, !bad);
        bus(1'h1, ADDR_CTRL, 32'h804, r);
        bus(1'h0, ADDR_RXBUF, 32'h0, r);
        chk(r & 32'hc0ff, {bad, bad, 6'h0, d});
        @(negedge mclk);
        chk(txo, 1'h1);
        bus(1'h1, ADDR_STAT, 32'h10, r);
    endtask : t_rx
    task automatic t_coll(input logic ss);
        logic [31:0] r;
        u_card.hold(1'h0);
        bus(1'h1, ADDR_CTRL, 32'h101 | (32'(ss) << C_COLL_SAMPLE), r);
        bus(1'h1, ADDR_TXBUF, 32'h1ff, r);
        repeat (4 * BT) @(posedge mclk);
        chk({coli, txoe}, {!ss, 1'h1});
        osu <= ss;
        @(posedge mclk) osu <= 1'h0;
        @(negedge mclk);
        chk(coli, 1'h1);
        bus(1'h0, ADDR_CTRL, 32'h0, r);
        chk(r[0], 1'h0);
        u_card.hold(1'h1);
        bus(1'h1, ADDR_STAT, 32'h20, r);
        @(negedge mclk);
        chk(coli, 1'h0);
    endtask : t_coll
    initial begin
        rd = 1'h0;
        wr = 1'h0;
        adr = 5'h0;
        wd = 32'h0;
        repeat (10) @(posedge mclk);
        srst <= 1'h0;
        t_regs;
        t_tx(1'h0, 8'ha5);
        t_tx(1'h1, 8'h3c);
        t_rx(1'h0, 8'h5a);
        t_rx(1'h1, 8'h96);
        t_coll(1'h0);
        t_coll(1'h1);
        summarize;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        summarize;
    end
endmodule : ucs_top_bench
bind ucs_top ucs_sva u_sva (.*);
`default_nettype wire
